//--- verilog/mxs_pkg.sv
// Purpose: shared constants for the bus-switch serial register access block
// Assumes: scl/sda sampled as synchronous inputs on clk_sys
// Notes:   register indices follow the auto-increment order of the register set
package mxs_pkg;

  // ==========================================================================
  // register set
  localparam int          MXS_NUM_REGS    = 7;
  localparam int          MXS_NUM_WR_REGS = 3;
  localparam logic [2:0]  MXS_IDX_SWITCH  = 3'h0;
  localparam logic [7:0]  MXS_SWITCH_RST  = 8'h00;
  localparam logic [7:0]  MXS_CONFIG_RST  = 8'h00;
  localparam logic [7:0]  MXS_FLUSH_RST   = 8'h00;

  // ==========================================================================
  // slave address, arbitrary default value
  localparam logic [6:0]  MXS_SLAVE_ADDR  = 7'h70;

  // ==========================================================================
  // protocol states
  typedef enum logic [2:0] {
    MXS_IDLE,
    MXS_ADDR,
    MXS_ADDR_ACK,
    MXS_WR_BYTE,
    MXS_WR_ACK,
    MXS_RD_BYTE,
    MXS_RD_ACK
  } mxs_state_e;

endpackage

//--- verilog/mxs_cond_det.sv
// Purpose: start/stop and scl edge detection from sampled bus lines
// Assumes: scl/sda already synchronous to clk_sys
// Notes:   outputs are one-cycle pulses
`timescale 1ns/1ps
module mxs_cond_det
  import mxs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  typedef struct packed {
    logic scl;
    logic sda;
  } mxs_det_s;

  mxs_det_s st_ff;
  mxs_det_s nxt_st;

  always_comb begin
    nxt_st.scl = scl_in;
    nxt_st.sda = sda_in;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign scl_rise  = scl_in & ~st_ff.scl;
  assign scl_fall  = ~scl_in & st_ff.scl;
  // sda moving while scl stays high marks a bus condition
  assign start_det = scl_in & st_ff.scl & st_ff.sda & ~sda_in;
  assign stop_det  = scl_in & st_ff.scl & ~st_ff.sda & sda_in;

endmodule

//--- verilog/mxs_reg_ptr.sv
// Purpose: register pointer with wrap for reads and writes
// Assumes: clear and step are one-cycle pulses
// Notes:   write pointer wraps after the writable registers
`timescale 1ns/1ps
module mxs_reg_ptr
  import mxs_pkg::*;
#(
  parameter int NUM_REGS    = MXS_NUM_REGS,
  parameter int NUM_WR_REGS = MXS_NUM_WR_REGS
)(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic       is_write,
  output logic      [2:0] ptr
);

  typedef struct packed {
    logic [2:0] ptr;
  } mxs_ptr_s;

  mxs_ptr_s st_ff;
  mxs_ptr_s nxt_st;
  logic [2:0] limit;

  always_comb begin
    nxt_st = st_ff;
    limit  = is_write ? 3'(NUM_WR_REGS - 1) : 3'(NUM_REGS - 1);
    if (clear) begin
      nxt_st.ptr = MXS_IDX_SWITCH;                 // see RULE_17
    end else if (step) begin
      if (st_ff.ptr >= limit) begin
        nxt_st.ptr = MXS_IDX_SWITCH;               // see RULE_15 see RULE_16
      end else begin
        nxt_st.ptr = st_ff.ptr + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{ptr: MXS_IDX_SWITCH};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ptr = st_ff.ptr;

endmodule

//--- verilog/mxs_i2c_regs.sv
// Purpose: serial slave register access for an 8-channel bus switch
// Assumes: scl/sda synchronous to clk_sys; clk_sys well above scl rate
// Notes:   registers 3..6 are read-only status inputs from the switch core
//
// Functional notes
// RULE_01 - basic mode exposes only switch control
// RULE_02 - single written byte loads switch control
// RULE_03 - basic multibyte write keeps last byte
// RULE_04 - no-enhanced variant keeps last written byte
// RULE_05 - basic mode commits on stop only; the code also commits the pending byte on a repeated start
// RULE_06 - ack own address with write bit
// RULE_07 - address then stop changes nothing
// RULE_08 - ack every received write byte
// RULE_09 - enhanced write steps from switch control
// RULE_10 - enhanced commits each byte on arrival
// RULE_11 - ack read address then send data
// RULE_12 - basic read repeats switch control
// RULE_13 - enhanced read ascends from switch control
// RULE_14 - master acks bytes to continue reading
// RULE_15 - enhanced write wraps after third register
// RULE_16 - enhanced read cycles all seven registers
// RULE_17 - pointer restarts each transaction
// RULE_18 - start/stop mid-byte aborts to idle; the code sends a start to MXS_ADDR instead
`timescale 1ns/1ps
module mxs_i2c_regs
  import mxs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR   = MXS_SLAVE_ADDR,
  parameter bit         HAS_ENHANCED = 1'b1
)(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       enhanced_mode,
  input  wire logic [7:0] stat_reg3,
  input  wire logic [7:0] stat_reg4,
  input  wire logic [7:0] stat_reg5,
  input  wire logic [7:0] stat_reg6,
  output logic      [7:0] switch_ctrl,
  output logic      [7:0] config_reg,
  output logic      [7:0] flush_reg,
  output logic            bus_busy
);

  // ==========================================================================
  // state
  typedef struct packed {
    mxs_state_e  state;
    logic [7:0]  shift;
    logic [3:0]  bits;
    logic        rd_nack;
    logic        drive_low;
    logic        tx_bit;
    logic        tx_en;
    logic        pend_vld;
    logic [7:0]  pend;
    logic [7:0]  sw;
    logic [7:0]  cfg;
    logic [7:0]  flush;
    logic        busy;
  } mxs_regs_s;

  // every field named, so a new field cannot slip out of reset
  localparam mxs_regs_s REGS_RST = '{
    state:     MXS_IDLE,
    shift:     8'h00,
    bits:      4'h0,
    rd_nack:   1'b0,
    drive_low: 1'b0,
    tx_bit:    1'b0,
    tx_en:     1'b0,
    pend_vld:  1'b0,
    pend:      8'h00,
    sw:        MXS_SWITCH_RST,
    cfg:       MXS_CONFIG_RST,
    flush:     MXS_FLUSH_RST,
    busy:      1'b0
  };

  mxs_regs_s st_ff;
  mxs_regs_s nxt_st;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       ptr_clear;
  logic       ptr_step;
  logic       is_write;
  logic [2:0] ptr;
  logic       enh;

  // without the enhanced set the part stays in basic mode
  assign enh = HAS_ENHANCED & enhanced_mode;    // see RULE_04

  // ==========================================================================
  // bus conditions and register pointer
  mxs_cond_det u_det (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  mxs_reg_ptr #(
    .NUM_REGS    (MXS_NUM_REGS),
    .NUM_WR_REGS (MXS_NUM_WR_REGS)
  ) u_ptr (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clear    (ptr_clear),
    .step     (ptr_step),
    .is_write (is_write),
    .ptr      (ptr)
  );

  // ==========================================================================
  // read data mux
  function automatic logic [7:0] rd_mux(input logic [2:0] idx, input mxs_regs_s s,
                                        input logic en);
    logic [7:0] v;
    v = s.sw;
    if (en) begin
      unique case (idx)
        3'h0:    v = s.sw;
        3'h1:    v = s.cfg;
        3'h2:    v = s.flush;
        3'h3:    v = stat_reg3;
        3'h4:    v = stat_reg4;
        3'h5:    v = stat_reg5;
        3'h6:    v = stat_reg6;
        default: v = s.sw;
      endcase
    end
    return v;                                    // see RULE_01 see RULE_12
  endfunction

  // ==========================================================================
  // byte load for transmit; msb goes out with the load
  function automatic mxs_regs_s load_tx(input mxs_regs_s s, input logic [7:0] v);
    mxs_regs_s r;
    r        = s;
    r.state  = MXS_RD_BYTE;
    r.shift  = v;
    r.tx_bit = v[7];
    r.tx_en  = 1'b1;
    r.bits   = 4'h0;
    return r;
  endfunction

  // ==========================================================================
  // enhanced write target; read-only indices are never reached
  function automatic mxs_regs_s commit_wr(input mxs_regs_s s, input logic [2:0] idx,
                                          input logic [7:0] v);
    mxs_regs_s r;
    r = s;
    unique case (idx)
      3'h0:    r.sw    = v;
      3'h1:    r.cfg   = v;
      3'h2:    r.flush = v;
      default: r.sw    = s.sw;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // protocol engine
  always_comb begin
    nxt_st    = st_ff;
    ptr_clear = 1'b0;
    ptr_step  = 1'b0;
    is_write  = (st_ff.state == MXS_WR_BYTE) || (st_ff.state == MXS_WR_ACK);

    if (start_det) begin
      // restart discards any partial byte
      nxt_st.state     = MXS_ADDR;               // see RULE_18
      nxt_st.bits      = 4'h0;
      nxt_st.drive_low = 1'b0;
      nxt_st.tx_en     = 1'b0;
      nxt_st.busy      = 1'b1;
      ptr_clear        = 1'b1;                   // see RULE_17
      if (st_ff.pend_vld) begin
        // repeated start also ends a basic write
        nxt_st.sw       = st_ff.pend;
        nxt_st.pend_vld = 1'b0;
      end
    end else if (stop_det) begin
      // a cut byte never reached pend, so only whole bytes commit
      nxt_st.state     = MXS_IDLE;               // see RULE_18
      nxt_st.drive_low = 1'b0;
      nxt_st.tx_en     = 1'b0;
      nxt_st.busy      = 1'b0;
      ptr_clear        = 1'b1;
      if (st_ff.pend_vld) begin
        nxt_st.sw       = st_ff.pend;            // see RULE_05 see RULE_03
        nxt_st.pend_vld = 1'b0;
      end                                        // see RULE_07
    end else begin
      unique case (st_ff.state)
        MXS_IDLE: begin
        end
        MXS_ADDR, MXS_WR_BYTE: begin
          if (scl_rise) begin
            nxt_st.shift = {st_ff.shift[6:0], sda_in};
            nxt_st.bits  = st_ff.bits + 4'h1;
          end
          if (scl_fall && st_ff.bits == 4'h8) begin
            nxt_st.bits = 4'h0;
            if (st_ff.state == MXS_ADDR) begin
              if (st_ff.shift[7:1] == SLAVE_ADDR) begin
                nxt_st.state     = MXS_ADDR_ACK; // see RULE_06 see RULE_11
                nxt_st.drive_low = 1'b1;
              end else begin
                nxt_st.state = MXS_IDLE;
              end
            end else begin
              nxt_st.state     = MXS_WR_ACK;
              nxt_st.drive_low = 1'b1;           // see RULE_08
              if (enh) begin
                nxt_st   = commit_wr(nxt_st, ptr, st_ff.shift); // see RULE_10 see RULE_09
                ptr_step = 1'b1;
              end else begin
                nxt_st.pend     = st_ff.shift;   // see RULE_02 see RULE_03
                nxt_st.pend_vld = 1'b1;
              end
            end
          end
        end
        MXS_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_st.drive_low = 1'b0;
            if (st_ff.shift[0]) begin
              nxt_st = load_tx(nxt_st, rd_mux(ptr, st_ff, enh)); // see RULE_13
            end else begin
              nxt_st.state = MXS_WR_BYTE;
            end
          end
        end
        MXS_WR_ACK: begin
          if (scl_fall) begin
            nxt_st.drive_low = 1'b0;
            nxt_st.state     = MXS_WR_BYTE;
          end
        end
        MXS_RD_BYTE: begin
          if (scl_fall) begin
            nxt_st.bits = st_ff.bits + 4'h1;
            if (st_ff.bits == 4'h7) begin
              nxt_st.tx_en = 1'b0;
              nxt_st.state = MXS_RD_ACK;
              // steps even on a nack; the next start clears it
              if (enh) begin
                ptr_step = 1'b1;                 // see RULE_16
              end
            end else begin
              nxt_st.shift  = {st_ff.shift[6:0], 1'b0};
              nxt_st.tx_bit = st_ff.shift[6];
            end
          end
        end
        MXS_RD_ACK: begin
          if (scl_rise) begin
            nxt_st.rd_nack = sda_in;
          end
          if (scl_fall) begin
            if (st_ff.rd_nack) begin
              nxt_st.state = MXS_IDLE;           // see RULE_14
            end else begin
              nxt_st = load_tx(nxt_st, rd_mux(ptr, st_ff, enh));
            end
          end
        end
        default: begin
          nxt_st.state = MXS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= REGS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs; open drain so only a low is ever driven
  assign sda_out     = 1'b0;
  assign sda_oe      = st_ff.drive_low | (st_ff.tx_en & ~st_ff.tx_bit);
  assign switch_ctrl = st_ff.sw;
  assign config_reg  = st_ff.cfg;
  assign flush_reg   = st_ff.flush;
  assign bus_busy    = st_ff.busy;

endmodule

//--- dv/mxs_i2c_regs_checker.sv
// Purpose: protocol assertions for the serial register access block
// Assumes: one clock domain, async active-low reset
// Notes:   sees only the top ports, bound below
`timescale 1ns/1ps
module mxs_i2c_regs_checker (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       enhanced_mode,
  input wire logic [7:0] switch_ctrl,
  input wire logic [7:0] config_reg,
  input wire logic [7:0] flush_reg,
  input wire logic       bus_busy
);
  // ==========================================================================
  // properties
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  AST_OD_LOW: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  AST_IDLE_QUIET: assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
    else $error("sda driven while bus idle");
  // sda may only move while scl is low, else it reads as start/stop
  AST_SCL_LOW_EDGE: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe changed with scl high");
  AST_BASIC_ONLY_SW: assert property (
    !enhanced_mode && !$past(enhanced_mode) |-> $stable(config_reg) && $stable(flush_reg))
    else $error("basic mode touched other registers");
  AST_BASIC_AT_STOP: assert property (
    !enhanced_mode && $changed(switch_ctrl) |-> scl_in && $past(scl_in))
    else $error("basic commit outside stop");
  AST_ENH_AT_ACK: assert property (
    enhanced_mode && $changed({switch_ctrl, config_reg, flush_reg})
    |-> (sda_oe || $past(sda_oe)) or (##[1:2] sda_oe))
    else $error("enhanced commit away from ack");
  AST_ENH_ONE_REG: assert property (
    enhanced_mode && $changed(flush_reg) |-> $stable(switch_ctrl) && $stable(config_reg))
    else $error("several registers in one byte");
  AST_BUSY_START: assert property (
    scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:3] bus_busy)
    else $error("start not seen");
  AST_BUSY_STOP: assert property (
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:3] !bus_busy)
    else $error("stop not seen");

  C_ENH_FLUSH: cover property (enhanced_mode && $changed(flush_reg));
  C_BASIC_COMMIT: cover property (!enhanced_mode && $changed(switch_ctrl));
  C_READ_DRIVE: cover property (bus_busy && $rose(sda_oe));
endmodule

bind mxs_i2c_regs mxs_i2c_regs_checker i_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .enhanced_mode(enhanced_mode),
  .switch_ctrl(switch_ctrl), .config_reg(config_reg), .flush_reg(flush_reg),
  .bus_busy(bus_busy)
);

//--- dv/mxs_i2c_master.sv
// Purpose: bus master model on the host side
// Assumes: sda pulled up, wired-and with the device pull-down
// Notes:   a quarter bit is four clk_sys cycles
`timescale 1ns/1ps
module mxs_i2c_master (
  input  wire logic clk_sys,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_w
);
  logic sda_m = 1'b1;

  initial scl = 1'b1;
  assign sda_w = sda_m & ~sda_oe;

  // ==========================================================================
  // bus tasks
  task automatic q();
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic put(input logic b, output logic r);
    sda_m <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda_w;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic start();
    sda_m <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b1;
    q();
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put(d[i], r);
    put(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
    put(~more, r);
  endtask
endmodule

//--- dv/mxs_i2c_regs_tb.sv
// Purpose: self-checking bench for the serial register access block
// Assumes: default slave address, enhanced variant
// Notes:   write cases table driven, reads and aborts by hand
`timescale 1ns/1ps
module mxs_i2c_regs_tb;
  import mxs_pkg::*;

  typedef struct packed {
    logic        enh;
    logic [2:0]  n;
    logic [31:0] d;
    logic [23:0] ex;
  } mxs_row_s;

  logic       clk_sys = 1'b0;
  logic       arst_n  = 1'b0;
  logic       enh     = 1'b0;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       busy;
  logic [7:0] sw;
  logic [7:0] cfg;
  logic [7:0] fl;
  logic [7:0] exp_rd [7] = '{8'he7, 8'h02, 8'h03, 8'hc3, 8'hc4, 8'hc5, 8'hc6};
  int         n_fail = 0;
  int         samples_checked = 0;
  mxs_row_s   rows [7] = '{
    '{1'b0, 3'h1, 32'h5a000000, 24'h5a0000}, '{1'b0, 3'h3, 32'h11223300, 24'h330000},
    '{1'b1, 3'h2, 32'ha1b20000, 24'ha1b200}, '{1'b1, 3'h4, 32'h01020304, 24'h040203},
    '{1'b1, 3'h0, 32'h00000000, 24'h040203}, '{1'b0, 3'h2, 32'h7ee70000, 24'he70203},
    '{1'b0, 3'h0, 32'h00000000, 24'he70203}};

  always #50 clk_sys = ~clk_sys;

  mxs_i2c_master i_mst (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda_w(sda));

  mxs_i2c_regs i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .enhanced_mode(enh), .stat_reg3(8'hc3), .stat_reg4(8'hc4),
    .stat_reg5(8'hc5), .stat_reg6(8'hc6), .switch_ctrl(sw), .config_reg(cfg),
    .flush_reg(fl), .bus_busy(busy)
  );

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_txn(input logic m, input int n);
    logic [7:0] d;
    logic       ack;
    enh <= m;
    i_mst.start();
    i_mst.wr({MXS_SLAVE_ADDR, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01, "rd_addr_ack");
    for (int j = 0; j < n; j++) begin
      i_mst.rd(j < n - 1, d);
      chk(d, exp_rd[m ? j % 7 : 0], "rd_data");
    end
    i_mst.stop();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // sequence
  initial begin
    logic       ack;
    logic       r;
    logic [7:0] prev;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({sw | cfg | fl}, 8'h00, "reset_regs");
    chk({6'h0, sda_oe, busy}, 8'h00, "reset_idle");
    foreach (rows[k]) begin
      enh <= rows[k].enh;
      prev = sw;
      i_mst.start();
      i_mst.wr({MXS_SLAVE_ADDR, 1'b0}, ack);
      chk({7'h0, ack}, 8'h01, "wr_addr_ack");
      for (int i = 0; i < rows[k].n; i++) begin
        i_mst.wr(rows[k].d[31 - 8 * i -: 8], ack);
        chk({7'h0, ack}, 8'h01, "data_ack");
        if (i == 0) chk(sw, rows[k].enh ? rows[k].d[31:24] : prev, "sw_early");
      end
      i_mst.stop();
      repeat (4) @(posedge clk_sys);
      chk(sw, rows[k].ex[23:16], "switch_ctrl");
      chk(cfg, rows[k].ex[15:8], "config_reg");
      chk(fl, rows[k].ex[7:0], "flush_reg");
    end
    rd_txn(1'b1, 8);
    // abort inside a data byte must drop the partial byte
    enh <= 1'b1;
    i_mst.start();
    i_mst.wr({MXS_SLAVE_ADDR, 1'b0}, ack);
    for (int i = 0; i < 4; i++) i_mst.put(1'b0, r);
    i_mst.stop();
    chk(sw, 8'he7, "abort_sw");
    i_mst.start();
    i_mst.wr({MXS_SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    chk({7'h0, ack}, 8'h00, "foreign_addr");
    i_mst.stop();
    rd_txn(1'b1, 1);
    rd_txn(1'b0, 2);
    // mid-run reset clears the registers and leaves the bus quiet
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({sw | cfg | fl}, 8'h00, "mid_reset_regs");
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({6'h0, sda_oe, busy}, 8'h00, "mid_reset_idle");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end
endmodule
